// ==== rtl/ups_pkg.sv ====
// Package for the transceiver status register bank: offsets, reset values, types.
// Assumes register cycles are already decoded from the link framing on CLK.
package ups_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] UPS_RISE_EN_BASE = 8'h0d;
    localparam logic [7:0] UPS_FALL_EN_BASE = 8'h10;
    localparam logic [7:0] UPS_LIVE_ADDR = 8'h13;
    localparam logic [7:0] UPS_STICKY_ADDR = 8'h14;
    localparam logic [7:0] UPS_DEBUG_ADDR = 8'h15;
    localparam logic [7:0] UPS_SPARE_BASE = 8'h16;
    localparam logic [7:0] UPS_EXT_GATE_ADDR = 8'h2f;
    localparam logic [7:0] UPS_PWR_BASE = 8'h3d;
    localparam logic [7:0] UPS_EXT_LIMIT = 8'h40;
    localparam logic [7:0] UPS_SET_OFS = 8'h01;
    localparam logic [7:0] UPS_CLR_OFS = 8'h02;
    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [4:0] UPS_EDGE_EN_RST = 5'h1f;
    localparam logic [7:0] UPS_SPARE_RST = 8'h00;
    localparam logic [7:0] UPS_PWR_RST = 8'h00;
    localparam logic [7:0] UPS_PWR_USED_MASK = 8'h0c;
    localparam int UPS_PWR_FALL_BIT = 3;
    localparam int UPS_PWR_RISE_BIT = 2;
    localparam logic [2:0] UPS_PAD3 = 3'h0;
    localparam logic [5:0] UPS_PAD6 = 6'h00;

    // Interrupt sources, same bit order as the live status byte
    typedef struct packed {
        logic id_grounded_level;
        logic session_end_level;
        logic session_valid_level;
        logic bus_power_valid_level;
        logic host_disconnect_level;
    } ups_src_t;

    // Decoded register access from the link
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] ext_addr;
        logic [7:0] wdata;
    } ups_req_t;

    typedef enum logic [2:0] {
        UPS_OP_NONE = 3'b001,
        UPS_OP_SET = 3'b010,
        UPS_OP_CLR = 3'b100
    } ups_op_t;
endpackage

// ==== rtl/ups_status_regs.sv ====
// Status, sticky, debug, spare and power-edge registers of the transceiver.
// Assumes the link framing decodes register cycles into one-cycle strobes on CLK,
// and that detector levels arrive asynchronously from the analog front end.
// ------------------------------------------------------------
// ------------------------------------------------------------
module ups_status_regs
    import ups_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [5:0] REG_ADDR,
    input wire logic [7:0] REG_EXT_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic LOW_POWER,
    input wire logic ID_GROUNDED_PIN,
    input wire logic SESSION_END_PIN,
    input wire logic SESSION_VALID_PIN,
    input wire logic BUS_POWER_VALID_PIN,
    input wire logic HOST_DISCONNECT_PIN,
    input wire logic B_SESSION_VALID_PIN,
    input wire logic [1:0] LINE_STATE_PIN,
    output logic [7:0] REG_RDATA,
    output logic REG_RACK,
    output logic RXCMD_REQ,
    output logic RXCMD_ALT_INT,
    output logic [4:0] RXCMD_SRC
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [7:0] pin_meta_r, pin_sync_r, pin_prev_r;
    logic first_r;
    ups_src_t src, src_prev;
    logic bvalid, bvalid_prev;
    logic [1:0] line_state;

    always_ff @(posedge CLK) begin
        pin_meta_r <= {ID_GROUNDED_PIN, SESSION_END_PIN, SESSION_VALID_PIN,
                       BUS_POWER_VALID_PIN, HOST_DISCONNECT_PIN,
                       B_SESSION_VALID_PIN, LINE_STATE_PIN};
        pin_sync_r <= pin_meta_r;
        pin_prev_r <= pin_sync_r;
    end

    // Suppress edge detection until prev holds a real sample
    always_ff @(posedge CLK) begin
        if (RST) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    assign src = ups_src_t'(pin_sync_r[7:3]);
    assign src_prev = ups_src_t'(pin_prev_r[7:3]);
    assign bvalid = pin_sync_r[2];
    assign bvalid_prev = pin_prev_r[2];
    assign line_state = pin_sync_r[1:0];

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    ups_req_t req;
    logic [7:0] eff_addr;
    logic mapped;

    assign req = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, ext_addr: REG_EXT_ADDR,
                   wdata: REG_WDATA};

    always_comb begin
        eff_addr = {2'h0, req.addr};
        if ({2'h0, req.addr} == UPS_EXT_GATE_ADDR) begin
            eff_addr = req.ext_addr;
        end
        // Extended 40h..FFh and alias of 2Fh itself touch nothing
        mapped = (eff_addr < UPS_EXT_LIMIT) && (eff_addr != UPS_EXT_GATE_ADDR);
    end

    function automatic ups_op_t op_at(input logic [7:0] a, input logic [7:0] base);
        if (a == base) begin
            op_at = UPS_OP_NONE;
        end else if (a == base + UPS_SET_OFS) begin
            op_at = UPS_OP_SET;
        end else begin
            op_at = UPS_OP_CLR;
        end
    endfunction

    function automatic logic hit3(input logic [7:0] a, input logic [7:0] base);
        hit3 = (a >= base) && (a <= base + UPS_CLR_OFS);
    endfunction

    function automatic logic [7:0] apply_op(input logic [7:0] cur, input logic [7:0] d,
                                            input ups_op_t op);
        case (op)
            UPS_OP_NONE: apply_op = d;
            UPS_OP_SET: apply_op = cur | d;
            UPS_OP_CLR: apply_op = cur & ~d;
            default: apply_op = cur;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    logic [7:0] rise_en_r, rise_en_nxt, fall_en_r, fall_en_nxt;
    logic [7:0] spare_r, spare_nxt, pwr_r, pwr_nxt;
    logic wr_ok;

    assign wr_ok = req.wr && mapped;

    always_comb begin
        rise_en_nxt = rise_en_r;
        fall_en_nxt = fall_en_r;
        spare_nxt = spare_r;
        pwr_nxt = pwr_r;
        if (wr_ok && hit3(eff_addr, UPS_RISE_EN_BASE)) begin
            rise_en_nxt = apply_op(rise_en_r, req.wdata, op_at(eff_addr, UPS_RISE_EN_BASE));
        end
        if (wr_ok && hit3(eff_addr, UPS_FALL_EN_BASE)) begin
            fall_en_nxt = apply_op(fall_en_r, req.wdata, op_at(eff_addr, UPS_FALL_EN_BASE));
        end
        if (wr_ok && hit3(eff_addr, UPS_SPARE_BASE)) begin
            spare_nxt = apply_op(spare_r, req.wdata, op_at(eff_addr, UPS_SPARE_BASE));
        end
        if (wr_ok && hit3(eff_addr, UPS_PWR_BASE)) begin
            // Reserved bits are stored as written; the link keeps them zero
            pwr_nxt = apply_op(pwr_r, req.wdata, op_at(eff_addr, UPS_PWR_BASE));
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rise_en_r <= {UPS_PAD3, UPS_EDGE_EN_RST};
            fall_en_r <= {UPS_PAD3, UPS_EDGE_EN_RST};
            spare_r <= UPS_SPARE_RST;
            pwr_r <= UPS_PWR_RST;
        end else begin
            rise_en_r <= rise_en_nxt;
            fall_en_r <= fall_en_nxt;
            spare_r <= spare_nxt;
            pwr_r <= pwr_nxt;
        end
    end

    // ------------------------------------------------------------
    // Edge events, sticky byte and receive commands
    // ------------------------------------------------------------
    logic [4:0] rise_ev, fall_ev, src_ev;
    logic b_rise, b_fall, alt_ev;
    logic [4:0] sticky_r, sticky_nxt;
    logic rd_sticky;
    logic rxreq_r, rxreq_nxt, rxalt_r, rxalt_nxt;
    logic [4:0] rxsrc_r, rxsrc_nxt;

    assign rise_ev = first_r ? 5'h00 : (src & ~src_prev & rise_en_r[4:0]);
    assign fall_ev = first_r ? 5'h00 : (~src & src_prev & fall_en_r[4:0]);
    assign src_ev = rise_ev | fall_ev;
    assign b_rise = !first_r && bvalid && !bvalid_prev && pwr_r[UPS_PWR_RISE_BIT];
    assign b_fall = !first_r && !bvalid && bvalid_prev && pwr_r[UPS_PWR_FALL_BIT];
    assign alt_ev = b_rise | b_fall;
    assign rd_sticky = req.rd && (eff_addr == UPS_STICKY_ADDR);

    always_comb begin
        sticky_nxt = sticky_r;
        if (rd_sticky || LOW_POWER) begin
            sticky_nxt = 5'h00;
        end
        // A new event in the clearing cycle survives the clear
        sticky_nxt = sticky_nxt | src_ev;
        rxreq_nxt = (|src_ev || alt_ev) && !LOW_POWER;
        // Alternate bit only travels with a command, never alone in low power
        rxalt_nxt = alt_ev && !LOW_POWER;
        rxsrc_nxt = src;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            sticky_r <= 5'h00;
            rxreq_r <= 1'b0;
            rxalt_r <= 1'b0;
            rxsrc_r <= 5'h00;
        end else begin
            sticky_r <= sticky_nxt;
            rxreq_r <= rxreq_nxt;
            rxalt_r <= rxalt_nxt;
            rxsrc_r <= rxsrc_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [7:0] rdata_r, rdata_nxt;
    logic rack_r, rack_nxt;

    always_comb begin
        rdata_nxt = 8'h00;
        rack_nxt = req.rd;
        if (req.rd && mapped) begin
            if (eff_addr == UPS_LIVE_ADDR) begin
                rdata_nxt = {UPS_PAD3, src};
            end else if (eff_addr == UPS_STICKY_ADDR) begin
                rdata_nxt = {UPS_PAD3, sticky_r};
            end else if (eff_addr == UPS_DEBUG_ADDR) begin
                rdata_nxt = {UPS_PAD6, line_state};
            end else if (hit3(eff_addr, UPS_RISE_EN_BASE)) begin
                rdata_nxt = rise_en_r;
            end else if (hit3(eff_addr, UPS_FALL_EN_BASE)) begin
                rdata_nxt = fall_en_r;
            end else if (hit3(eff_addr, UPS_SPARE_BASE)) begin
                rdata_nxt = spare_r;
            end else if (hit3(eff_addr, UPS_PWR_BASE)) begin
                rdata_nxt = pwr_r;
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_r <= 8'h00;
            rack_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rack_r <= rack_nxt;
        end
    end

    assign REG_RDATA = rdata_r;
    assign REG_RACK = rack_r;
    assign RXCMD_REQ = rxreq_r;
    assign RXCMD_ALT_INT = rxalt_r;
    assign RXCMD_SRC = rxsrc_r;
endmodule

// ==== test/ups_properties.sv ====
// Checker for the status register bank, watching top ports only.
// Assumes one clock and a synchronous active-high reset.
module ups_properties (
    input wire logic CLK,
    input wire logic RST,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [5:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic LOW_POWER,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_RACK,
    input wire logic RXCMD_REQ,
    input wire logic RXCMD_ALT_INT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // ----
    // Properties
    // ----
    AST_RACK: assert property (REG_RD |=> REG_RACK)
        else $error("read not answered");
    AST_IDLE_BUS: assert property (!REG_RD |=> !REG_RACK && REG_RDATA == 8'h00)
        else $error("answer without read");
    AST_LIVE_PAD: assert property (REG_RD && REG_ADDR == 6'h13 |=> REG_RDATA[7:5] == 3'h0)
        else $error("status pad bits set");
    AST_DEBUG_PAD: assert property (REG_RD && REG_ADDR == 6'h15 |=> REG_RDATA[7:2] == 6'h00)
        else $error("debug pad bits set");
    AST_HOLE: assert property (REG_RD && REG_ADDR inside {[6'h19:6'h2e]} |=> REG_RDATA == 8'h00)
        else $error("hole read not zero");
    AST_SPARE: assert property (REG_WR && REG_ADDR == 6'h16 ##2 REG_RD && REG_ADDR == 6'h16
        |=> REG_RDATA == $past(REG_WDATA, 3))
        else $error("spare byte lost");
    AST_LP_QUIET: assert property (LOW_POWER && $past(LOW_POWER) |-> !RXCMD_REQ)
        else $error("command in low power");
    AST_ALT_REQ: assert property (RXCMD_ALT_INT |-> RXCMD_REQ)
        else $error("alternate bit without command");
    // Main scenarios reached
    cover property (REG_RD && REG_ADDR == 6'h14 ##1 REG_RDATA != 8'h00);
    cover property (RXCMD_REQ && RXCMD_ALT_INT);
    cover property (LOW_POWER ##1 !LOW_POWER);
endmodule

bind ups_status_regs ups_properties CHK (.CLK, .RST, .REG_WR, .REG_RD, .REG_ADDR,
    .REG_WDATA, .LOW_POWER, .REG_RDATA, .REG_RACK, .RXCMD_REQ, .RXCMD_ALT_INT);

// ==== test/ups_link_model.sv ====
// Link controller model issuing decoded register strobes.
// Assumes strobes change on the falling edge of the bank clock.
module ups_link_model (
    input wire logic CLK,
    output logic REG_WR = 1'b0,
    output logic REG_RD = 1'b0,
    output logic [5:0] REG_ADDR = 6'h00,
    output logic [7:0] REG_EXT_ADDR = 8'h00,
    output logic [7:0] REG_WDATA = 8'h00
);
    // ----
    // One access, strobe held for one edge
    // ----
    task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] x,
            input logic [7:0] d);
        logic pwr;
        pwr = (a == 6'h2f ? x : {2'h0, a}) inside {[8'h3d:8'h3f]};
        @(negedge CLK);
        REG_WR = w;
        REG_RD = !w;
        REG_ADDR = a;
        REG_EXT_ADDR = x & 8'h3f;
        REG_WDATA = pwr ? (d & 8'h0c) : d;
        @(negedge CLK);
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        // Stale data inverted so a late sample cannot pass
        REG_WDATA = ~REG_WDATA;
    endtask
endmodule

// ==== test/tb_top.sv ====
// Testbench for the status register bank with queued expectations.
// Assumes reads answer one cycle later and source edges raise commands.
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module tb_top
    import ups_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0, RST = 1'b1, LOW_POWER = 1'b0, bsv = 1'b0;
    logic [1:0] line = 2'h0;
    ups_src_t pins = '0;
    logic REG_WR, REG_RD, REG_RACK, RXCMD_REQ, RXCMD_ALT_INT;
    logic [5:0] REG_ADDR, ec;
    logic [7:0] REG_EXT_ADDR, REG_WDATA, REG_RDATA, spare, er;
    logic [4:0] RXCMD_SRC;
    logic [31:0] seed = 32'h4d74;
    int n_fail = 0, check_count = 0;
    logic [7:0] rq[$];
    logic [5:0] cq[$];
    initial forever #4 CLK = ~CLK;
    ups_link_model LINK (.CLK, .REG_WR, .REG_RD, .REG_ADDR, .REG_EXT_ADDR, .REG_WDATA);
    ups_status_regs DUT (.CLK, .RST, .REG_WR, .REG_RD, .REG_ADDR, .REG_EXT_ADDR,
        .REG_WDATA, .LOW_POWER, .ID_GROUNDED_PIN(pins.id_grounded_level),
        .SESSION_END_PIN(pins.session_end_level),
        .SESSION_VALID_PIN(pins.session_valid_level),
        .BUS_POWER_VALID_PIN(pins.bus_power_valid_level),
        .HOST_DISCONNECT_PIN(pins.host_disconnect_level), .B_SESSION_VALID_PIN(bsv),
        .LINE_STATE_PIN(line), .REG_RDATA, .REG_RACK, .RXCMD_REQ, .RXCMD_ALT_INT,
        .RXCMD_SRC);
    // ----
    // Helpers and monitor
    // ----
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic report_and_stop();
        // An expectation never answered is a hang, not a pass
        if (rq.size() != 0 || cq.size() != 0) n_fail++;
        $display("checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [7:0] x = 8'h00);
        LINK.acc(1'b1, a, x, d);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] x = 8'h00);
        rq.push_back(e);
        LINK.acc(1'b0, a, x, 8'h00);
    endtask
    // Waits for the queued command, then idles so stray pulses surface
    task automatic setp(input ups_src_t v, input logic b, input logic ev, input logic alt);
        @(negedge CLK);
        pins = v;
        bsv = b;
        if (ev) cq.push_back({alt, v});
        for (int i = 0; i < 12 && cq.size() != 0; i++) @(negedge CLK);
        repeat (4) @(negedge CLK);
        if (cq.size() != 0) begin
            n_fail++;
            report_and_stop();
        end
    endtask
    always @(negedge CLK) begin
        if (REG_RACK === 1'b1 && rq.size() != 0) begin
            er = rq.pop_front();
            `CHK(REG_RDATA, er)
        end else if (REG_RACK !== 1'b0 && !RST) `CHK(REG_RACK, 1'b0)
        if (RXCMD_REQ === 1'b1 && cq.size() != 0) begin
            ec = cq.pop_front();
            `CHK({RXCMD_ALT_INT, RXCMD_SRC}, ec)
        end else if (RXCMD_REQ !== 1'b0 && !RST) `CHK(RXCMD_REQ, 1'b0)
    end
    // ----
    // Main sequence
    // ----
    initial begin
        repeat (6) @(negedge CLK);
        RST = 1'b0;
        rd(6'h0d, 8'h1f);
        rd(6'h10, 8'h1f);
        rd(6'h14, 8'h00);
        rd(6'h16, 8'h00);
        rd(6'h3d, 8'h00);
        seed = lfsr(seed);
        spare = seed[7:0];
        wr(6'h16, spare);
        rd(6'h16, spare);
        wr(6'h17, 8'h5a);
        rd(6'h17, spare | 8'h5a);
        wr(6'h18, 8'h0f);
        spare = (spare | 8'h5a) & 8'hf0;
        rd(6'h18, spare);
        for (int a = 'h19; a <= 'h2e; a++) wr(a[5:0], 8'hff);
        rd(6'h20, 8'h00);
        rd(6'h16, spare);
        wr(6'h2f, 8'h3c, 8'h16);
        rd(6'h16, 8'h3c);
        rd(6'h2f, 8'h3c, 8'h16);
        line = 2'h2;
        rd(6'h2f, 8'h00, 8'h2f);
        rd(6'h15, 8'h02);
        setp(5'h10, 1'b0, 1'b1, 1'b0);
        rd(6'h13, 8'h10);
        rd(6'h14, 8'h10);
        rd(6'h14, 8'h00);
        wr(6'h0f, 8'h10);
        setp(5'h00, 1'b0, 1'b1, 1'b0);
        rd(6'h14, 8'h10);
        setp(5'h10, 1'b0, 1'b0, 1'b0);
        rd(6'h14, 8'h00);
        setp(5'h12, 1'b0, 1'b1, 1'b0);
        LOW_POWER = 1'b1;
        // Enabled fall in low power: no command, sticky cleared again
        pins = 5'h02;
        repeat (4) @(negedge CLK);
        LOW_POWER = 1'b0;
        rd(6'h14, 8'h00);
        rd(6'h13, 8'h02);
        wr(6'h3d, 8'hff);
        rd(6'h3d, 8'h0c);
        setp(5'h12, 1'b1, 1'b1, 1'b1);
        setp(5'h12, 1'b0, 1'b1, 1'b1);
        report_and_stop();
    end
endmodule
